/* File: core/video_sample_pkg.sv */
package video_sample_pkg;
    // Register addresses on the plain register port.
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_CLAMP      = 4'h1;
    localparam logic [3:0]  ADDR_OFFSET_R   = 4'h2;
    localparam logic [3:0]  ADDR_OFFSET_G   = 4'h3;
    localparam logic [3:0]  ADDR_OFFSET_B   = 4'h4;
    localparam logic [3:0]  ADDR_GAIN_R     = 4'h5;
    localparam logic [3:0]  ADDR_GAIN_G     = 4'h6;
    localparam logic [3:0]  ADDR_GAIN_B     = 4'h7;
    localparam logic [3:0]  ADDR_STATUS     = 4'h8;
    // Control register field positions.
    localparam int          CTRL_CLAMP_BIT  = 0;
    localparam int          CTRL_CDS_BIT    = 1;
    localparam int          CTRL_MONO_BIT   = 2;
    localparam int          CTRL_POS_LSB    = 3;
    localparam int          CTRL_SET_LSB    = 5;
    localparam int          CTRL_EXT_BIT    = 7;
    localparam int          CLAMP_RNG_BIT   = 4;
    // Reset values: double sampling on, everything else cleared.
    localparam logic [7:0]  CTRL_RESET      = 8'h02;
    localparam logic [7:0]  CLAMP_RESET     = 8'h00;
    localparam logic [7:0]  CODE_RESET      = 8'h00;
    // Colour set select encodings.
    localparam logic [1:0]  SET_RED         = 2'h0;
    localparam logic [1:0]  SET_GREEN       = 2'h1;
    localparam logic [1:0]  SET_BLUE        = 2'h2;
    localparam logic [1:0]  SET_RESERVED    = 2'h3;
    // Pixel timing in master clock cycles after the detected sync edge.
    localparam logic [2:0]  RESET_PH_BASE   = 3'h1;
    localparam logic [2:0]  VIDEO_PH        = 3'h6;
    localparam logic [2:0]  PH_MAX          = 3'h7;
    // Output word and nibble sizes.
    localparam int          WORD_W          = 16;
    localparam int          NIB_W           = 4;
    localparam logic [1:0]  LAST_NIB        = 2'h3;
endpackage

/* File: core/pair_buffer.sv */
`timescale 1ns/10ps
module pair_buffer #(
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk_in,
    input  wire logic             srst_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wp;
        logic                  rp;
        logic [1:0]            cnt;
    } buf_s;

    buf_s st_q;
    buf_s st_d;
    logic push;
    logic pop;

    // Full and empty come straight from the count, so the source sees a true stall.
    assign in_ready_out  = (st_q.cnt != 2'h2);
    assign out_valid_out = (st_q.cnt != 2'h0);
    assign out_data_out  = st_q.mem[st_q.rp];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // Two slots used as a ring; a push and a pop in one cycle keep the count.
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = in_data_in;
            st_d.wp           = ~st_q.wp;
        end
        if (pop) begin
            st_d.rp = ~st_q.rp;
        end
        st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
    end

    // Contents, pointers and count all clear together on reset.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st_q     <= '0;
        end else begin
            st_q     <= st_d;
        end
    end
endmodule

/* File: core/video_sample_control.sv */
`timescale 1ns/10ps
// Behaviour
// [R1] Capture clamp request bit on the clock edge inside each pixel sync pulse.
// [R2] Captured one gives a force pulse in the next reset level; zero suppresses it.
// [R3] Force pulse comes only from clock and sync, and only while request is high.
// [R4] Input-to-reference switch is closed exactly while the force pulse is active.
// [R5] Two-bit position field sets force pulse and reset strobe timing.
// [R6] Double sampling, default on, references video to the sampled reset level.
// [R7] Without double sampling, reset strobe fires with the video strobe.
// [R8] Clamping works in both double-sampling and single-ended modes.
// [R9] Separate eight-bit offset and gain codes for red, green and blue.
// [R10] Colour select picks which codes feed offset converter and gain stage.
// [R11] Monochrome applies one fixed code pair to every pixel.
// [R12] Four-bit clamp level code drives reference pin; range bit widens it.
// [R13] External clamp level bit disables the internal clamp level converter.
// [R14] Each sixteen-bit conversion leaves on a four-bit bus.
// [R15] Colour select 00 red, 01 green, 10 blue, 11 reserved.
// [R16] Nibbles leave most significant first: d15-d12 down to d3-d0.
// [R17] A new colour selection takes effect from the next sampled pixel.
// [R18] The controller changes colour selection only between lines.
module video_sample_control
    import video_sample_pkg::*;
(
    // Clock, reset and the asynchronous pixel sync pin.
    input  wire logic                                 ref_clk_in,
    input  wire logic                                 srst_in,
    input  wire logic                                 pixel_sync_pulse_in,

    // Plain register port; read data stands one cycle after the strobe.
    input  wire logic [video_sample_pkg::ADDR_W-1:0]  reg_addr_in,
    input  wire logic [7:0]                           reg_wdata_in,
    input  wire logic                                 reg_wr_in,
    input  wire logic                                 reg_rd_in,
    output logic      [7:0]                           reg_rdata_out,

    // Conversion words from the converter, same clock domain.
    input  wire logic [video_sample_pkg::WORD_W-1:0]  conv_data_in,
    input  wire logic                                 conv_valid_in,
    output logic                                      conv_ready_out,

    // Pixel timing strobes and the input switch.
    output logic                                      reset_level_force_pulse_out,
    output logic                                      clamp_switch_close_out,
    output logic                                      reset_sample_strobe_out,
    output logic                                      video_sample_strobe_out,

    // Referencing, colour codes and clamp level converter controls.
    output logic                                      ref_from_reset_out,
    output logic      [7:0]                           colour_offset_code_out,
    output logic      [7:0]                           colour_gain_code_out,
    output logic      [3:0]                           clamp_level_code_out,
    output logic                                      clamp_level_range_out,
    output logic                                      clamp_level_converter_en_out,

    // Nibble bus towards the scanner controller.
    output logic      [video_sample_pkg::NIB_W-1:0]   nibble_output_bus_out,
    output logic                                      nibble_valid_out,
    input  wire logic                                 nibble_ready_in
);
    import video_sample_pkg::*;

    // All state except the output buffer's lives in one packed record that is registered once per clock.
    typedef struct packed {
        logic [2:0]        sync_ff;
        logic              sync_stable;
        logic [2:0]        ph;
        logic              clamp_cap;
        logic [1:0]        act_set;
        logic [7:0]        ctrl;
        logic [7:0]        clamp;
        logic [2:0][7:0]   offs;
        logic [2:0][7:0]   gain;
        logic [7:0]        rdata;
        logic              force_p;
        logic              rs_strobe;
        logic              vs_strobe;
        logic [7:0]        offs_out;
        logic [7:0]        gain_out;
        logic [WORD_W-1:0] sh;
        logic [1:0]        nib_cnt;
        logic              busy;
    } state_s;

    state_s            st_q;
    state_s            st_d;
    // Decoded control fields and the derived reset strobe phase.
    logic              sync_edge;
    logic              clamp_req;
    logic              cds_on;
    logic              mono_on;
    logic [1:0]        rs_pos;
    logic [1:0]        set_req;
    logic [2:0]        rs_ph;
    // Handshake between the output buffer and the serializer.
    logic [WORD_W-1:0] buf_data;
    logic              buf_valid;
    logic              buf_ready;
    logic              load;

    // Field views of the control register.
    assign clamp_req = st_q.ctrl[CTRL_CLAMP_BIT];
    assign cds_on    = st_q.ctrl[CTRL_CDS_BIT];
    assign mono_on   = st_q.ctrl[CTRL_MONO_BIT];
    assign rs_pos    = st_q.ctrl[CTRL_POS_LSB +: 2];
    assign set_req   = st_q.ctrl[CTRL_SET_LSB +: 2];
    assign rs_ph     = RESET_PH_BASE + {1'b0, rs_pos};

    // A sync edge counts once the second and third stages agree high.
    // The first stage feeds only the second, so metastability stays contained.
    // A sync pulse shorter than two clocks may be filtered out entirely.
    assign sync_edge = st_q.sync_ff[1] & st_q.sync_ff[2] & ~st_q.sync_stable;

    // The serializer takes a new word when idle or while its last nibble leaves.
    assign buf_ready = ~st_q.busy | (nibble_ready_in & (st_q.nib_cnt == LAST_NIB));
    assign load      = buf_valid & buf_ready;

    // Conversions wait here while the receiver stalls the nibble bus.
    pair_buffer #(
        .WIDTH (WORD_W)
    ) u_out_buf (
        .ref_clk_in    (ref_clk_in),
        .srst_in       (srst_in),
        .in_data_in    (conv_data_in),
        .in_valid_in   (conv_valid_in),
        .in_ready_out  (conv_ready_out),
        .out_data_out  (buf_data),
        .out_valid_out (buf_valid),
        .out_ready_in  (buf_ready)
    );

    // Next-state logic for sync detection, pixel timing, registers and output.
    always_comb begin
        st_d             = st_q;
        st_d.sync_ff     = {st_q.sync_ff[1:0], pixel_sync_pulse_in};
        if (st_q.sync_ff[1] == st_q.sync_ff[2]) begin
            st_d.sync_stable = st_q.sync_ff[2];
        end

        // Phase restarts at each sync edge and saturates between pixels.
        if (sync_edge) begin
            st_d.ph        = RESET_PH_BASE;
            st_d.clamp_cap = clamp_req;                          // [R1]
            if (mono_on) begin
                st_d.act_set = SET_RED;                          // [R11]
            end else if (set_req != SET_RESERVED) begin
                st_d.act_set = set_req;                          // [R15] [R17]
            end
        end else if (st_q.ph != PH_MAX) begin
            st_d.ph = st_q.ph + 3'h1;
        end

        // Clamping is not gated by the referencing mode.
        st_d.force_p   = st_d.clamp_cap & clamp_req & (st_d.ph == rs_ph);  // [R2] [R3] [R5] [R8]
        st_d.vs_strobe = (st_d.ph == VIDEO_PH);
        st_d.rs_strobe = cds_on ? (st_d.ph == rs_ph) : st_d.vs_strobe;     // [R5] [R7]

        // The active set is latched per pixel so codes never mix inside one.
        st_d.offs_out  = st_q.offs[st_q.act_set];                // [R10]
        st_d.gain_out  = st_q.gain[st_q.act_set];                // [R10]

        // Register writes; an unmapped write is ignored.
        // Control holds clamp request, double sampling and monochrome in bits 0 to 2.
        // Bits 4:3 set the reset sample position, 6:5 the colour set, 7 the external level.
        // Clamp keeps the level code in bits 3:0 and the range in bit 4; the rest read zero.
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                ADDR_CTRL:     st_d.ctrl    = reg_wdata_in;
                ADDR_CLAMP:    st_d.clamp   = {3'h0, reg_wdata_in[4:0]};
                ADDR_OFFSET_R: st_d.offs[0] = reg_wdata_in;      // [R9]
                ADDR_OFFSET_G: st_d.offs[1] = reg_wdata_in;
                ADDR_OFFSET_B: st_d.offs[2] = reg_wdata_in;
                ADDR_GAIN_R:   st_d.gain[0] = reg_wdata_in;
                ADDR_GAIN_G:   st_d.gain[1] = reg_wdata_in;
                ADDR_GAIN_B:   st_d.gain[2] = reg_wdata_in;
                default:       st_d.ctrl    = st_q.ctrl;
            endcase
        end

        // Read data stands only in the cycle after the read strobe.
        // Status packs busy, sync level, captured request and the active set.
        st_d.rdata = 8'h00;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_CTRL:     st_d.rdata = st_q.ctrl;
                ADDR_CLAMP:    st_d.rdata = st_q.clamp;
                ADDR_OFFSET_R: st_d.rdata = st_q.offs[0];
                ADDR_OFFSET_G: st_d.rdata = st_q.offs[1];
                ADDR_OFFSET_B: st_d.rdata = st_q.offs[2];
                ADDR_GAIN_R:   st_d.rdata = st_q.gain[0];
                ADDR_GAIN_G:   st_d.rdata = st_q.gain[1];
                ADDR_GAIN_B:   st_d.rdata = st_q.gain[2];
                ADDR_STATUS:   st_d.rdata = {3'h0, st_q.busy, st_q.sync_stable,
                                             st_q.clamp_cap, st_q.act_set};
                default:       st_d.rdata = 8'h00;
            endcase
        end

        // Nibble serializer: shift out the top nibble on each accepted beat.
        // A stalled nibble simply waits; words behind it queue in the buffer.
        if (load) begin
            st_d.sh      = buf_data;                             // [R14]
            st_d.nib_cnt = 2'h0;
            st_d.busy    = 1'b1;
        end else if (st_q.busy & nibble_ready_in) begin
            if (st_q.nib_cnt == LAST_NIB) begin
                st_d.busy = 1'b0;
            end else begin
                st_d.sh      = {st_q.sh[WORD_W-NIB_W-1:0], {NIB_W{1'b0}}};  // [R16]
                st_d.nib_cnt = st_q.nib_cnt + 2'h1;
            end
        end
    end

    // All state registers except the output buffer's together; reset gives double sampling and red codes.
    // The phase starts saturated, so no strobe fires before the first sync edge.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st_q       <= '0;
            st_q.ph    <= PH_MAX;
            st_q.ctrl  <= CTRL_RESET;                            // [R6]
            st_q.clamp <= CLAMP_RESET;
            st_q.offs  <= {3{CODE_RESET}};
            st_q.gain  <= {3{CODE_RESET}};
        end else begin
            st_q       <= st_d;
        end
    end

    // Outputs; the switch follows the force pulse with no extra delay.
    assign reset_level_force_pulse_out  = st_q.force_p;
    assign clamp_switch_close_out       = st_q.force_p;               // [R4]
    assign reset_sample_strobe_out      = st_q.rs_strobe;
    assign video_sample_strobe_out      = st_q.vs_strobe;
    assign ref_from_reset_out           = cds_on;                     // [R6]
    assign colour_offset_code_out       = st_q.offs_out;
    assign colour_gain_code_out         = st_q.gain_out;
    assign clamp_level_code_out         = st_q.clamp[3:0];            // [R12]
    assign clamp_level_range_out        = st_q.clamp[CLAMP_RNG_BIT];  // [R12]
    assign clamp_level_converter_en_out = ~st_q.ctrl[CTRL_EXT_BIT];   // [R13]
    assign nibble_output_bus_out        = st_q.sh[WORD_W-1 -: NIB_W];
    assign nibble_valid_out             = st_q.busy;
    assign reg_rdata_out                = st_q.rdata;

    // Checks that sit beside the logic they guard.
    sequence sync_seen;
        sync_edge;
    endsequence

    sequence word_taken;
        load;
    endsequence

    a_clamp_capture: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R1]
        sync_seen |=> (st_q.clamp_cap == $past(clamp_req)))
        else $error("clamp request not captured at sync edge");

    a_force_gated: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R2]
        reset_level_force_pulse_out |-> (st_q.clamp_cap && $past(clamp_req)))
        else $error("force pulse without captured clamp request");

    a_switch_release: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R4]
        $fell(reset_level_force_pulse_out) |-> !clamp_switch_close_out)
        else $error("input switch not released after force pulse");

    a_reset_position: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R5]
        (reset_sample_strobe_out && $past(cds_on) && !video_sample_strobe_out)
            |-> (st_q.ph == RESET_PH_BASE + {1'b0, $past(rs_pos)}))
        else $error("reset strobe at wrong phase");

    a_single_ended: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R7]
        (video_sample_strobe_out && !$past(cds_on)) |-> reset_sample_strobe_out)
        else $error("reset strobe missing beside video strobe");

    a_colour_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R17]
        !sync_edge |=> $stable(st_q.act_set))
        else $error("colour set changed mid pixel");

    a_mono_codes: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R11]
        (mono_on && $past(sync_edge, 2)) |-> (st_q.act_set == SET_RED))
        else $error("monochrome not on fixed code pair");

    a_ext_clamp: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R13]
        st_q.ctrl[CTRL_EXT_BIT] |-> !clamp_level_converter_en_out)
        else $error("clamp converter enabled with external level");

    a_nibble_first: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R16]
        word_taken |=> (nibble_valid_out && nibble_output_bus_out == $past(buf_data[15:12])))
        else $error("first nibble not the top of the word");

    a_nibble_count: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R14]
        (word_taken ##1 nibble_ready_in [*4]) |=> !(st_q.busy && st_q.nib_cnt != 2'h0))
        else $error("word not sent in four nibbles");

    // Further checks on pixel timing, colour codes and the nibble bus.
    sequence video_seen;
        video_sample_strobe_out;
    endsequence

    sequence nibble_stalled;
        nibble_valid_out && !nibble_ready_in;
    endsequence

    a_switch_close: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R4]
        reset_level_force_pulse_out |-> clamp_switch_close_out)
        else $error("input switch open during force pulse");

    a_force_request: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R3]
        !clamp_req |=> !reset_level_force_pulse_out)
        else $error("force pulse with clamp request low");

    // Strobe width and phase checks.
    a_force_single: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R2]
        reset_level_force_pulse_out |=> !reset_level_force_pulse_out)
        else $error("force pulse longer than one cycle");

    a_video_phase: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R5]
        video_seen |-> (st_q.ph == VIDEO_PH))
        else $error("video strobe at wrong phase");

    a_video_single: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R5]
        video_seen |=> !video_sample_strobe_out)
        else $error("video strobe longer than one cycle");

    // Colour code checks.
    a_colour_select: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R15]
        (sync_edge && !mono_on && set_req != SET_RESERVED) |=> (st_q.act_set == $past(set_req)))
        else $error("colour set not taken at sync edge");

    a_reserved_keep: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R15]
        (sync_edge && !mono_on && set_req == SET_RESERVED) |=> $stable(st_q.act_set))
        else $error("reserved colour select changed the set");

    a_codes_steady: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R17]
        (!sync_edge && !reg_wr_in) |-> ##2 ($stable(colour_offset_code_out) && $stable(colour_gain_code_out)))
        else $error("colour codes changed inside a pixel");

    // Nibble bus stall check.
    a_nibble_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [R14]
        nibble_stalled |=> (nibble_valid_out && $stable(nibble_output_bus_out)))
        else $error("nibble lost during a stall");
endmodule

/* File: sim/nibble_receiver.sv */
`timescale 1ns/10ps
// Scanner-side receiver: gathers nibbles into words and stalls when told to.
module nibble_receiver (
    input  wire logic        ref_clk_in,
    input  wire logic        srst_in,
    input  wire logic [3:0]  nibble_in,
    input  wire logic        nibble_valid_in,
    input  wire logic        stall_in,
    output logic             ready_out,
    output logic      [15:0] word_out,
    output logic             word_done_out
);
    logic [1:0]  count_q;
    logic [11:0] part_q;

    // A nibble counts only on an edge with valid and ready both high, so a stall never loses one.
    always_ff @(posedge ref_clk_in) begin
        word_done_out <= 1'b0;
        if (srst_in) begin
            count_q   <= 2'h0;
            part_q    <= 12'h000;
            ready_out <= 1'b0;
            word_out  <= 16'h0000;
        end else begin
            ready_out <= !stall_in;
            if (nibble_valid_in && ready_out) begin
                part_q  <= {part_q[7:0], nibble_in};
                count_q <= count_q + 2'h1;
                if (count_q == 2'h3) begin
                    word_out      <= {part_q, nibble_in};
                    word_done_out <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: sim/video_sample_control_tb.sv */
`timescale 1ns/10ps
module video_sample_control_tb;
    import video_sample_pkg::*;
    logic        ref_clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        sync = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [7:0]  rdata;
    logic [15:0] cdata = 16'h0000;
    logic        cvalid = 1'b0;
    logic        cready, force_p, sw, rstb, vstb, ref_rst, rng, conv_en, nvalid, nready, done, stall = 1'b1;
    logic [7:0]  off_c, gain_c;
    logic [3:0]  lvl, nib;
    logic [15:0] word;
    logic [31:0] rs = 32'd38836;
    logic [31:0] ss = 32'd38836;
    logic        rd_seen = 1'b0;
    logic [15:0] wq[$];
    logic [7:0]  rq[$];
    logic [7:0]  c[6];
    int          fails = 0;
    int          checks = 0;

    video_sample_control uut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .pixel_sync_pulse_in(sync),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .conv_data_in(cdata), .conv_valid_in(cvalid), .conv_ready_out(cready),
        .reset_level_force_pulse_out(force_p), .clamp_switch_close_out(sw), .reset_sample_strobe_out(rstb),
        .video_sample_strobe_out(vstb), .ref_from_reset_out(ref_rst), .colour_offset_code_out(off_c),
        .colour_gain_code_out(gain_c), .clamp_level_code_out(lvl), .clamp_level_range_out(rng),
        .clamp_level_converter_en_out(conv_en), .nibble_output_bus_out(nib), .nibble_valid_out(nvalid),
        .nibble_ready_in(nready));
    nibble_receiver rx (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .nibble_in(nib), .nibble_valid_in(nvalid),
        .stall_in(stall), .ready_out(nready), .word_out(word), .word_done_out(done));

    // Half period of 5 ns gives the 100 MHz master clock.
    always #5 ref_clk_in = !ref_clk_in;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Each bus task leaves one idle edge so no strobe is assigned twice in a time step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk_in);
        wr_s <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        rq.push_back(exp);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk_in);
        rd_s <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    // One pixel: program control, pulse sync, and record the cycle of every strobe.
    task automatic pixel(input logic [1:0] p, input logic cl, input logic double_sample_enable, input logic [1:0] s,
                         input logic mono, input logic [1:0] es);
        int f, r, v, fc, rc, vc, n;
        f = -100; r = -100; v = -100; fc = 0; rc = 0; vc = 0;
        wr(ADDR_CTRL, {1'b0, s, p, mono, double_sample_enable, cl});
        sync <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge ref_clk_in);
            if (n == 3) sync <= 1'b0;
            if (sw !== force_p) chk("switch vs force", 16'(force_p), 16'(sw));
            if (force_p === 1'b1) begin f = n; fc++; end
            if (rstb === 1'b1) begin r = n; rc++; end
            if (vstb === 1'b1) begin v = n; vc++; end
        end
        chk("video strobes", 16'h0001, 16'(vc));
        chk("force count", 16'(cl), 16'(fc));
        if (cl) chk("force cycle", 16'(v - 5 + p), 16'(f));
        chk("reset strobes", 16'h0001, 16'(rc));
        chk("reset cycle", 16'(double_sample_enable ? v - 5 + p : v), 16'(r));
        chk("ref select", 16'(double_sample_enable), 16'(ref_rst));
        chk("offset code", 16'(c[es]), 16'(off_c));
        chk("gain code", 16'(c[es + 3]), 16'(gain_c));
    endtask

    task automatic send_word(input logic [15:0] w);
        int n;
        cdata <= w;
        cvalid <= 1'b1;
        wq.push_back(w);
        @(posedge ref_clk_in);
        for (n = 0; n < 200 && cready !== 1'b1; n++) @(posedge ref_clk_in);
    endtask

    // Results are taken off the queues as they show up at the outputs.
    always @(posedge ref_clk_in) begin
        if (done === 1'b1) begin
            if (wq.size() == 0) chk("unexpected word", 16'h0000, 16'hFFFF);
            else chk("word", wq.pop_front(), word);
        end
        if (rd_seen) chk("read data", 16'(rq.pop_front()), 16'(rdata));
        rd_seen <= rd_s;
    end

    // The far side stalls at random once the fill test has released it.
    logic stall_mode = 1'b0;
    always @(posedge ref_clk_in) begin
        ss = xs(ss);
        if (stall_mode) stall <= ss[3];
    end

    // Tests need well under 2000 cycles; ten times that margin catches a hang.
    initial begin
        #200000;
        fails++;
        end_of_test();
    end

    initial begin
        logic [1:0] sets[8];
        logic [1:0] prev, es;
        int         i, n;
        sets = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h0, 2'h3, 2'h2};
        repeat (8) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        @(posedge ref_clk_in);
        chk("converter enable", 16'h0001, 16'(conv_en));
        chk("input ready", 16'h0001, 16'(cready));
        rd(ADDR_CTRL, 8'h02);
        rd(4'hF, 8'h00);
        for (i = 0; i < 6; i++) begin
            rs = xs(rs);
            c[i] = rs[7:0];
            wr(4'(i + 2), c[i]);
        end
        for (i = 0; i < 6; i++) rd(4'(i + 2), c[i]);
        wr(ADDR_CLAMP, 8'hFF);
        rd(ADDR_CLAMP, 8'h1F);
        chk("clamp level", 16'h000F, 16'(lvl));
        chk("clamp range", 16'h0001, 16'(rng));
        wr(ADDR_CTRL, 8'h82);
        @(posedge ref_clk_in);
        chk("converter enable", 16'h0000, 16'(conv_en));
        prev = 2'h0;
        for (i = 0; i < 8; i++) begin
            es = (i == 7) ? 2'h0 : (sets[i] == 2'h3) ? prev : sets[i];
            if (i != 7) prev = es;
            pixel(2'(i), i != 5, i < 4, sets[i], i == 7, es);
        end
        rd(ADDR_STATUS, 8'h04);
        for (n = 0; n < 3; n++) begin
            rs = xs(rs);
            send_word(rs[15:0]);
        end
        cvalid <= 1'b0;
        @(posedge ref_clk_in);
        chk("buffer refuses", 16'h0000, 16'(cready));
        stall_mode <= 1'b1;
        for (i = 0; i < 20; i++) begin
            rs = xs(rs);
            send_word(rs[15:0]);
        end
        cvalid <= 1'b0;
        for (n = 0; n < 600 && wq.size() != 0; n++) @(posedge ref_clk_in);
        chk("words left", 16'h0000, 16'(wq.size()));
        end_of_test();
    end
endmodule
